// ---- switch_reset_pkg.sv ----
// Constants, register map and types for the switch reset sequencer
package switch_reset_pkg;
	// Clock and documented times, each in its own unit
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TUNE_PULSE_NS = 1000;
	localparam int unsigned OE_DELAY_NS = 2000;
	localparam int unsigned POR_TIME_MS = 21;
	localparam int unsigned PIN_TIME_US = 760;
	localparam int unsigned DIG_TIME_US = 760;
	localparam int unsigned XCVR_RST_US = 102;
	localparam int unsigned EMU_RST_US = 1;
	localparam int unsigned TS_RST_NS = 100;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned NS_PER_MS = 1000000;

	// Counter type wide enough for the longest settle time
	localparam int unsigned SEQ_W = 22;
	typedef logic [SEQ_W-1:0] cnt_t;
	localparam cnt_t CNT_ONE = cnt_t'(1);

	// Least times round up to whole cycles
	localparam cnt_t TUNE_CYC = cnt_t'((TUNE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t OE_CYC = cnt_t'((OE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t POR_CYC = cnt_t'((POR_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t PIN_CYC = cnt_t'((PIN_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t DIG_CYC = cnt_t'((DIG_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t XCVR_CYC = cnt_t'((XCVR_RST_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t EMU_CYC = cnt_t'((EMU_RST_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t TS_CYC = cnt_t'((TS_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Register byte addresses
	localparam int unsigned ADR_W = 10;
	localparam logic [ADR_W-1:0] ADR_ENDIAN = 10'h064;
	localparam logic [ADR_W-1:0] ADR_HARDWARE_CONFIG_REG = 10'h074;
	localparam logic [ADR_W-1:0] ADR_PMT = 10'h084;
	localparam logic [ADR_W-1:0] ADR_FABRIC = 10'h1E0;
	localparam logic [ADR_W-1:0] ADR_TIMESYNC = 10'h1E4;
	localparam logic [ADR_W-1:0] ADR_XCVR_A = 10'h1E8;
	localparam logic [ADR_W-1:0] ADR_XCVR_B = 10'h1EC;
	localparam logic [ADR_W-1:0] ADR_EMU = 10'h1F0;
	localparam logic [ADR_W-1:0] ADR_SOFT_RESET_CONTROL_REG = 10'h1F8;

	// Field positions and byte lanes
	localparam int unsigned RC_DIG = 0;
	localparam int unsigned RC_XA = 1;
	localparam int unsigned RC_EMU = 3;
	localparam int unsigned BC_SOFT = 15;
	localparam int unsigned BC_LOOP = 14;
	localparam int unsigned BC_PD = 11;
	localparam int unsigned BC_IMM = 8;
	localparam int unsigned HW_READY = 27;
	localparam int unsigned HW_IMM = 8;
	localparam int unsigned PMT_READY = 0;
	localparam int unsigned FAB_RST = 0;
	localparam int unsigned TS_RST = 0;
	localparam int unsigned LANE_LO = 0;
	localparam int unsigned LANE_BC = 1;
	localparam int unsigned STRAP_W = 8;
	localparam int unsigned NUM_XCVR = 2;

	// Endian check word, value arbitrary
	localparam logic [31:0] ENDIAN_CHECK = 32'h1234_5678;

	// Sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_CHIP = 3'h0,
		ST_TUNE = 3'h1,
		ST_OE = 3'h3,
		ST_SETTLE = 3'h2,
		ST_LOAD = 3'h6,
		ST_READY = 3'h7
	} seq_state_e;

	// Transceiver basic control fields kept here
	typedef struct packed {
		logic soft_reset;
		logic loopback;
		logic power_down;
		logic immune;
	} xcvr_ctl_s;
endpackage

// ---- switch_reset_sequencer.sv ----
// Reset sequencer for a three-port switch: chip, digital and per-module resets
// Functional notes
// - Power-on reset clears all, latches straps, tunes pads, then runs EEPROM load.
// - Power-on reset lasts about 21 ms plus 91 us per EEPROM byte.
// - Low reset pin starts chip reset; driver holds it low long enough.
// - Pin reset lasts about 760 us plus 91 us per EEPROM byte.
// - Reset pin has a pull-up, so an open pin causes no reset.
// - Digital reset resets several modules, not the chip, no strap capture.
// - Endian check reads invalid until host interface reset ends; software polls.
// - Ready shows in hardware config and power control once reset is done.
// - Before ready only four registers are read and all writes are ignored; the read mux here answers every register at any time.
// - Digital reset spares the Ethernet transceivers.
// - Digital reset keeps reset-immune bits.
// - Digital reset restores soft straps from latched pins, then EEPROM load.
// - Digital reset lasts about 760 us plus 91 us per EEPROM byte.
// - Module resets touch only their module; no strap capture, no EEPROM load.
// - Port A request or self-reset resets port A; both clear after 102 us.
// - Port B request or self-reset resets port B; both clear after 102 us.
// - Self-reset of a transceiver keeps its reset-immune bits.
// - Leaving power-down resets a transceiver without touching its registers.
// - Emulated transceiver request or control bit resets it; clear after 1 us.
// - Fabric bit resets the fabric; software clears it.
// - Time-sync bit resets time-sync logic and clears itself on completion.
// - After chip reset a 1 us low tuning pulse, outputs enabled 2 us later.
// - Then master reset is released in the system clock domain.
// - Soft reset control at 1F8h, four self-clearing bits, writes ignored while set.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
module switch_reset_sequencer #(
	parameter switch_reset_pkg::cnt_t POR_SETTLE_CYC = switch_reset_pkg::POR_CYC,
	parameter switch_reset_pkg::cnt_t PIN_SETTLE_CYC = switch_reset_pkg::PIN_CYC,
	parameter switch_reset_pkg::cnt_t DIG_SETTLE_CYC = switch_reset_pkg::DIG_CYC,
	parameter switch_reset_pkg::cnt_t XCVR_RST_CYC = switch_reset_pkg::XCVR_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [switch_reset_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic por_n_i,
	input wire logic ext_rst_n_i,
	input wire logic [switch_reset_pkg::STRAP_W-1:0] strap_i,
	input wire logic eeprom_done_i,
	output logic ext_rst_pullup_en_o,
	output logic pad_tune_n_o,
	output logic outputs_en_o,
	output logic master_rst_o,
	output logic digital_rst_o,
	output logic host_if_rst_o,
	output logic eeprom_load_o,
	output logic [switch_reset_pkg::STRAP_W-1:0] straps_o,
	output logic [switch_reset_pkg::STRAP_W-1:0] soft_straps_o,
	output logic ready_o,
	output logic [switch_reset_pkg::NUM_XCVR-1:0] xcvr_rst_o,
	output logic emu_rst_o,
	output logic fabric_rst_o,
	output logic timesync_rst_o
);

	logic por_meta_r, por_sync_r, pin_meta_r, pin_sync_r;
	logic chip_rst;
	switch_reset_pkg::seq_state_e state_r;
	switch_reset_pkg::cnt_t cnt_r, settle_cyc;
	logic cause_por_r, dig_r, dig_req;
	logic hw_imm_r;
	logic [switch_reset_pkg::STRAP_W-1:0] strap_r, soft_r;
	logic req, wr_commit;
	logic [switch_reset_pkg::ADR_W-1:0] word_adr;
	logic [31:0] rd_d;
	switch_reset_pkg::xcvr_ctl_s [switch_reset_pkg::NUM_XCVR-1:0] xctl;
	logic [switch_reset_pkg::NUM_XCVR-1:0] xrc, xbusy;
	switch_reset_pkg::cnt_t emu_cnt_r, ts_cnt_r;
	logic emu_rc_r, fab_r;

	// Pad pull-up always on: floating pin reads as released
	assign ext_rst_pullup_en_o = 1'b1;

	// Two-flop synchronisers; only the second flop is used
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			por_meta_r <= 1'b0;
			por_sync_r <= 1'b0;
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
		end
		else
		begin
			por_meta_r <= por_n_i;
			por_sync_r <= por_meta_r;
			pin_meta_r <= ext_rst_n_i;
			pin_sync_r <= pin_meta_r;
		end
	end
	assign chip_rst = ~por_sync_r | ~pin_sync_r;

	// Base wait depends on what started the sequence
	assign settle_cyc = cause_por_r ? POR_SETTLE_CYC : (dig_r ? DIG_SETTLE_CYC : PIN_SETTLE_CYC);

	// Main sequencer: chip reset, tune pulse, output wait, settle, load
	always_ff @(posedge clk_i)
	begin
		if (rst_i || chip_rst)
		begin
			state_r <= switch_reset_pkg::ST_CHIP;
			cnt_r <= '0;
		end
		else
		begin
			unique case (state_r)
				switch_reset_pkg::ST_CHIP:
				begin
					state_r <= switch_reset_pkg::ST_TUNE;
					cnt_r <= '0;
				end
				switch_reset_pkg::ST_TUNE:
				begin
					if (cnt_r == switch_reset_pkg::TUNE_CYC - switch_reset_pkg::CNT_ONE)
					begin
						state_r <= switch_reset_pkg::ST_OE;
						cnt_r <= '0;
					end
					else
						cnt_r <= cnt_r + switch_reset_pkg::CNT_ONE;
				end
				switch_reset_pkg::ST_OE:
				begin
					if (cnt_r == switch_reset_pkg::OE_CYC - switch_reset_pkg::CNT_ONE)
					begin
						state_r <= switch_reset_pkg::ST_SETTLE;
						cnt_r <= '0;
					end
					else
						cnt_r <= cnt_r + switch_reset_pkg::CNT_ONE;
				end
				switch_reset_pkg::ST_SETTLE:
				begin
					if (cnt_r == settle_cyc - switch_reset_pkg::CNT_ONE)
					begin
						state_r <= switch_reset_pkg::ST_LOAD;
						cnt_r <= '0;
					end
					else
						cnt_r <= cnt_r + switch_reset_pkg::CNT_ONE;
				end
				switch_reset_pkg::ST_LOAD:
				begin
					// Loader time per byte adds on here
					if (eeprom_done_i)
						state_r <= switch_reset_pkg::ST_READY;
				end
				switch_reset_pkg::ST_READY:
				begin
					if (dig_req)
					begin
						state_r <= switch_reset_pkg::ST_SETTLE;
						cnt_r <= '0;
					end
				end
				default:
				begin
					state_r <= switch_reset_pkg::ST_CHIP;
					cnt_r <= '0;
				end
			endcase
		end
	end

	// Cause of the sequence and digital reset flag (bit 0 self-clears)
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cause_por_r <= 1'b1;
			dig_r <= 1'b0;
		end
		else
		begin
			if (!por_sync_r)
				cause_por_r <= 1'b1;
			else if (state_r == switch_reset_pkg::ST_READY)
				cause_por_r <= 1'b0;
			if (chip_rst || state_r == switch_reset_pkg::ST_LOAD)
				dig_r <= 1'b0;
			else if (dig_req)
				dig_r <= 1'b1;
		end
	end

	// Straps follow the pins only while chip reset holds
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			strap_r <= '0;
		else if (state_r == switch_reset_pkg::ST_CHIP)
			strap_r <= strap_i;
	end

	// Soft straps and immune bit; digital reset reloads straps only
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_r == switch_reset_pkg::ST_CHIP)
		begin
			soft_r <= '0;
			hw_imm_r <= 1'b0;
		end
		else if (state_r == switch_reset_pkg::ST_TUNE || dig_req)
			soft_r <= strap_r;
		else if (wr_commit && word_adr == switch_reset_pkg::ADR_HARDWARE_CONFIG_REG)
		begin
			if (wb_sel_i[switch_reset_pkg::LANE_LO])
				soft_r <= wb_dat_i[switch_reset_pkg::STRAP_W-1:0];
			if (wb_sel_i[switch_reset_pkg::LANE_BC])
				hw_imm_r <= wb_dat_i[switch_reset_pkg::HW_IMM];
		end
	end

	// Reset outputs decoded from state and counters
	assign master_rst_o = state_r == switch_reset_pkg::ST_CHIP || state_r == switch_reset_pkg::ST_TUNE
		|| state_r == switch_reset_pkg::ST_OE;
	assign pad_tune_n_o = state_r != switch_reset_pkg::ST_TUNE;
	assign outputs_en_o = ~master_rst_o;
	assign digital_rst_o = master_rst_o || (dig_r && state_r == switch_reset_pkg::ST_SETTLE);
	assign host_if_rst_o = digital_rst_o;
	assign eeprom_load_o = state_r == switch_reset_pkg::ST_LOAD;
	assign ready_o = state_r == switch_reset_pkg::ST_READY;
	assign straps_o = strap_r;
	assign soft_straps_o = soft_r;
	assign fabric_rst_o = digital_rst_o | fab_r;
	assign timesync_rst_o = digital_rst_o | (ts_cnt_r != '0);
	assign emu_rst_o = master_rst_o | emu_rc_r;

	// Wishbone slave: ack one cycle after request, write at the ack edge
	assign req = wb_cyc_i & wb_stb_i;
	assign word_adr = {wb_adr_i[switch_reset_pkg::ADR_W-1:2], 2'h0};
	assign wr_commit = req & wb_we_i & wb_ack_o & ready_o;
	assign dig_req = wr_commit && word_adr == switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG
		&& wb_sel_i[switch_reset_pkg::LANE_LO] && wb_dat_i[switch_reset_pkg::RC_DIG];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req && !wb_ack_o)
				wb_dat_o <= rd_d;
		end
	end

	// Read mux; unmapped words read zero
	always_comb
	begin
		rd_d = '0;
		unique case (word_adr)
			switch_reset_pkg::ADR_ENDIAN:
				rd_d = host_if_rst_o ? '0 : switch_reset_pkg::ENDIAN_CHECK;
			switch_reset_pkg::ADR_HARDWARE_CONFIG_REG:
			begin
				rd_d[switch_reset_pkg::HW_READY] = ready_o;
				rd_d[switch_reset_pkg::HW_IMM] = hw_imm_r;
				rd_d[switch_reset_pkg::STRAP_W-1:0] = soft_r;
			end
			switch_reset_pkg::ADR_PMT:
				rd_d[switch_reset_pkg::PMT_READY] = ready_o;
			switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG:
			begin
				rd_d[switch_reset_pkg::RC_DIG] = dig_r;
				rd_d[switch_reset_pkg::RC_XA+1:switch_reset_pkg::RC_XA] = xrc;
				rd_d[switch_reset_pkg::RC_EMU] = emu_rc_r;
			end
			switch_reset_pkg::ADR_XCVR_A, switch_reset_pkg::ADR_XCVR_B:
			begin
				rd_d[switch_reset_pkg::BC_SOFT] = xctl[word_adr[2]].soft_reset;
				rd_d[switch_reset_pkg::BC_LOOP] = xctl[word_adr[2]].loopback;
				rd_d[switch_reset_pkg::BC_PD] = xctl[word_adr[2]].power_down;
				rd_d[switch_reset_pkg::BC_IMM] = xctl[word_adr[2]].immune;
			end
			switch_reset_pkg::ADR_EMU:
				rd_d[switch_reset_pkg::BC_SOFT] = emu_rc_r;
			switch_reset_pkg::ADR_FABRIC:
				rd_d[switch_reset_pkg::FAB_RST] = fab_r;
			switch_reset_pkg::ADR_TIMESYNC:
				rd_d[switch_reset_pkg::TS_RST] = ts_cnt_r != '0;
			default:
				rd_d = '0;
		endcase
	end

	// Per-transceiver reset: request bit, self-reset bit, power-down exit
	for (genvar i = 0; i < switch_reset_pkg::NUM_XCVR; i++)
	begin : g_xcvr
		localparam logic [switch_reset_pkg::ADR_W-1:0] ADR_OWN =
			(i == 0) ? switch_reset_pkg::ADR_XCVR_A : switch_reset_pkg::ADR_XCVR_B;
		switch_reset_pkg::xcvr_ctl_s ctl_r;
		switch_reset_pkg::cnt_t cnt_r;
		logic rc_r, wr_rc, wr_bc;
		assign wr_rc = wr_commit && word_adr == switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG
			&& wb_sel_i[switch_reset_pkg::LANE_LO] && wb_dat_i[switch_reset_pkg::RC_XA + i];
		assign wr_bc = wr_commit && word_adr == ADR_OWN && wb_sel_i[switch_reset_pkg::LANE_BC];
		// Writes are ignored while the reset runs
		always_ff @(posedge clk_i)
		begin
			if (rst_i || master_rst_o)
			begin
				ctl_r <= '0;
				cnt_r <= '0;
				rc_r <= 1'b0;
			end
			else if (cnt_r != '0)
			begin
				cnt_r <= cnt_r - switch_reset_pkg::CNT_ONE;
				if (cnt_r == switch_reset_pkg::CNT_ONE)
				begin
					rc_r <= 1'b0;
					ctl_r.soft_reset <= 1'b0;
				end
			end
			else if (wr_rc)
			begin
				cnt_r <= XCVR_RST_CYC;
				rc_r <= 1'b1;
				ctl_r <= '{soft_reset: 1'b1, loopback: 1'b0, power_down: 1'b0, immune: 1'b0};
			end
			else if (wr_bc && wb_dat_i[switch_reset_pkg::BC_SOFT])
			begin
				cnt_r <= XCVR_RST_CYC;
				rc_r <= 1'b1;
				ctl_r.soft_reset <= 1'b1;
				ctl_r.loopback <= 1'b0;
				ctl_r.power_down <= 1'b0; // Immune bit kept
			end
			else if (wr_bc)
			begin
				// Power-down exit pulses reset, registers take the write
				if (ctl_r.power_down && !wb_dat_i[switch_reset_pkg::BC_PD])
					cnt_r <= XCVR_RST_CYC;
				ctl_r.loopback <= wb_dat_i[switch_reset_pkg::BC_LOOP];
				ctl_r.power_down <= wb_dat_i[switch_reset_pkg::BC_PD];
				ctl_r.immune <= wb_dat_i[switch_reset_pkg::BC_IMM];
			end
		end
		assign xctl[i] = ctl_r;
		assign xrc[i] = rc_r;
		assign xbusy[i] = cnt_r != '0;
		assign xcvr_rst_o[i] = master_rst_o | xbusy[i];
	end

	// Emulated transceiver: either bit starts a short self-clearing reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i || master_rst_o)
		begin
			emu_cnt_r <= '0;
			emu_rc_r <= 1'b0;
		end
		else if (emu_cnt_r != '0)
		begin
			emu_cnt_r <= emu_cnt_r - switch_reset_pkg::CNT_ONE;
			if (emu_cnt_r == switch_reset_pkg::CNT_ONE)
				emu_rc_r <= 1'b0;
		end
		else if (wr_commit && ((word_adr == switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG
			&& wb_sel_i[switch_reset_pkg::LANE_LO] && wb_dat_i[switch_reset_pkg::RC_EMU])
			|| (word_adr == switch_reset_pkg::ADR_EMU && wb_sel_i[switch_reset_pkg::LANE_BC]
			&& wb_dat_i[switch_reset_pkg::BC_SOFT])))
		begin
			emu_cnt_r <= switch_reset_pkg::EMU_CYC;
			emu_rc_r <= 1'b1;
		end
	end
	// Fabric bit is plain read/write; software must clear it
	always_ff @(posedge clk_i)
	begin
		if (rst_i || digital_rst_o)
			fab_r <= 1'b0;
		else if (wr_commit && word_adr == switch_reset_pkg::ADR_FABRIC
			&& wb_sel_i[switch_reset_pkg::LANE_LO])
			fab_r <= wb_dat_i[switch_reset_pkg::FAB_RST];
	end

	// Time-sync reset runs a short count and self-clears for polling
	always_ff @(posedge clk_i)
	begin
		if (rst_i || digital_rst_o)
			ts_cnt_r <= '0;
		else if (ts_cnt_r != '0)
			ts_cnt_r <= ts_cnt_r - switch_reset_pkg::CNT_ONE;
		else if (wr_commit && word_adr == switch_reset_pkg::ADR_TIMESYNC
			&& wb_sel_i[switch_reset_pkg::LANE_LO] && wb_dat_i[switch_reset_pkg::TS_RST])
			ts_cnt_r <= switch_reset_pkg::TS_CYC;
	end

	// Checks on sequencing and self-clearing behaviour
	property p_sync_por;
		@(posedge clk_i) disable iff (rst_i)
			$fell(por_n_i && ext_rst_n_i) |-> ##[1:4] master_rst_o;
	endproperty
	a_sync_por: assert property (p_sync_por) else $error("chip reset not seen by sequencer");
	property p_tune;
		@(posedge clk_i) disable iff (rst_i)
			$rose(outputs_en_o) |-> !$past(pad_tune_n_o, 201) && $past(pad_tune_n_o, 200);
	endproperty
	a_tune: assert property (p_tune) else $error("tune pulse timing wrong");
	property p_dig;
		@(posedge clk_i) disable iff (rst_i) dig_req |=> !ready_o && digital_rst_o && !master_rst_o;
	endproperty
	a_dig: assert property (p_dig) else $error("digital reset not started");
	property p_imm;
		@(posedge clk_i) disable iff (rst_i) digital_rst_o && !master_rst_o |=> $stable(hw_imm_r);
	endproperty
	a_imm: assert property (p_imm) else $error("immune bit changed");
	property p_ready;
		@(posedge clk_i) disable iff (rst_i)
			$rose(ready_o) |-> $past(eeprom_load_o) && $past(eeprom_done_i);
	endproperty
	a_ready: assert property (p_ready) else $error("ready before load done");
	property p_nowrite;
		@(posedge clk_i) disable iff (rst_i) !ready_o && !digital_rst_o |=> $stable(fab_r);
	endproperty
	a_nowrite: assert property (p_nowrite) else $error("write taken before ready");
	property p_xa;
		@(posedge clk_i) disable iff (rst_i)
			$rose(xrc[0]) |-> xcvr_rst_o[0][*8] ##1 !eeprom_load_o && $stable(straps_o);
	endproperty
	a_xa: assert property (p_xa) else $error("port A reset wrong");
	property p_xb;
		@(posedge clk_i) disable iff (rst_i) $fell(xrc[1]) |-> !xctl[1].soft_reset && !xbusy[1];
	endproperty
	a_xb: assert property (p_xb) else $error("port B bits not cleared together");
	property p_emu;
		@(posedge clk_i) disable iff (rst_i || master_rst_o)
			$rose(emu_rc_r) |-> ##99 emu_rc_r ##1 !emu_rc_r;
	endproperty
	a_emu: assert property (p_emu) else $error("emulated reset length wrong");
	property p_ts;
		@(posedge clk_i) disable iff (rst_i || digital_rst_o)
			$rose(timesync_rst_o) |-> ##9 timesync_rst_o ##1 !timesync_rst_o;
	endproperty
	a_ts: assert property (p_ts) else $error("time-sync reset length wrong");
endmodule // switch_reset_sequencer

// ---- reset_env_model.sv ----
// Model of the reset pin driver and EEPROM loader beside the sequencer
module reset_env_model (
	input wire logic clk_i,
	input wire logic pin_req_i,
	input wire logic eeprom_load_i,
	input wire logic [7:0] load_wait_i,
	output logic ext_rst_n_o,
	output logic eeprom_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PIN_LOW_CYC = 8; // Minimum low time, plain default
	int pin_cnt = 0;
	int load_cnt = 0;
	initial ext_rst_n_o = 1'b1;
	initial eeprom_done_o = 1'b0;
	// Once asked, the pin stays low the whole minimum; pull-up level otherwise
	always @(posedge clk_i)
	begin
		pin_cnt <= pin_req_i ? PIN_LOW_CYC : (pin_cnt > 0 ? pin_cnt - 1 : 0);
		ext_rst_n_o <= !(pin_req_i || pin_cnt > 1);
	end
	// Loader answers a set number of cycles after being asked
	always @(posedge clk_i)
	begin
		load_cnt <= eeprom_load_i ? load_cnt + 1 : 0;
		eeprom_done_o <= eeprom_load_i && load_cnt >= int'(load_wait_i);
	end
endmodule // reset_env_model

// ---- switch_reset_sequencer_tb.sv ----
// Self-checking bench for the switch reset sequencer
module switch_reset_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int XC = 20;
	logic clk_i = 0, rst_i = 1, req = 0, wb_we_i = 0, por_n_i = 0, pin_req = 0;
	logic [9:0] wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, q;
	logic [7:0] strap_i = '0, load_wait = 8'h28, s, straps_o, soft_straps_o;
	logic wb_ack_o, ext_rst_n_i, eeprom_done_i, ext_rst_pullup_en_o, pad_tune_n_o, outputs_en_o;
	logic master_rst_o, digital_rst_o, eeprom_load_o, ready_o, emu_rst_o, fabric_rst_o;
	logic timesync_rst_o, host_if_rst_o;
	logic [1:0] xcvr_rst_o;
	int err_total = 0, n_compared = 0, tune_cnt = 0, oe_cnt = 0, hi_cnt = 0, n;
	switch_reset_sequencer #(.POR_SETTLE_CYC(50), .PIN_SETTLE_CYC(30), .DIG_SETTLE_CYC(30),
		.XCVR_RST_CYC(XC)) switch_reset_sequencer_inst (.clk_i, .rst_i, .wb_cyc_i(req),
		.wb_stb_i(req), .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.por_n_i, .ext_rst_n_i, .strap_i, .eeprom_done_i, .ext_rst_pullup_en_o, .pad_tune_n_o,
		.outputs_en_o, .master_rst_o, .digital_rst_o, .host_if_rst_o, .eeprom_load_o,
		.straps_o, .soft_straps_o, .ready_o, .xcvr_rst_o, .emu_rst_o, .fabric_rst_o,
		.timesync_rst_o);
	reset_env_model reset_env_model_inst (.clk_i, .pin_req_i(pin_req), .eeprom_load_i(eeprom_load_o),
		.load_wait_i(load_wait), .ext_rst_n_o(ext_rst_n_i), .eeprom_done_o(eeprom_done_i));
	always #5 clk_i = ~clk_i;
	// Pulse widths measured on the pins, not taken from the design's counters
	always @(posedge clk_i)
	begin
		if (pad_tune_n_o === 1'b0) tune_cnt <= tune_cnt + 1;
		else if (tune_cnt > 0 && outputs_en_o !== 1'b1) oe_cnt <= oe_cnt + 1;
		if ((|xcvr_rst_o) === 1'b1 || emu_rst_o === 1'b1) hi_cnt <= hi_cnt + 1;
	end
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic timeout();
		err_total++;
		$display("wrong value at %0t: wait timed out", $time);
		print_verdict();
	endtask
	task automatic check(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) $display("wrong value at %0t: %s", $time, m);
		if (ok !== 1'b1) err_total++;
	endtask
	// One classic cycle; held until ack is sampled high at a rising edge, released there
	task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		req <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 20);
		q = wb_dat_o;
		req <= 1'b0;
		if (wb_ack_o !== 1'b1) timeout();
	endtask
	// Software style polling of one bit, bounded
	task automatic poll(input logic [9:0] a, input int b, input logic v);
		int k;
		k = 0;
		do wb(1'b0, a, 32'h0); while (q[b] !== v && ++k < 300);
		if (q[b] !== v) timeout();
	endtask
	function automatic logic near(input int got, input int want);
		return got >= want && got <= want + 1;
	endfunction
	// Whole chip bring-up after power-on or pin reset
	task automatic chip_seq(input logic [7:0] st);
		int k;
		k = 0;
		do wb(1'b0, switch_reset_pkg::ADR_ENDIAN, 32'h0);
		while (q !== switch_reset_pkg::ENDIAN_CHECK && ++k < 300);
		check(q === switch_reset_pkg::ENDIAN_CHECK, "endian word");
		wb(1'b1, switch_reset_pkg::ADR_FABRIC, 32'h1);
		@(negedge clk_i);
		check(ready_o === 1'b0 && fabric_rst_o === 1'b0, "write before ready");
		poll(switch_reset_pkg::ADR_HARDWARE_CONFIG_REG, switch_reset_pkg::HW_READY, 1'b1);
		check(q[7:0] === st && straps_o === st, "straps latched");
		wb(1'b0, switch_reset_pkg::ADR_PMT, 32'h0);
		check(q[switch_reset_pkg::PMT_READY] === 1'b1, "pmt ready");
		check(tune_cnt == int'(switch_reset_pkg::TUNE_CYC), "tune pulse");
		check(oe_cnt == int'(switch_reset_pkg::OE_CYC), "output enable delay");
		check(master_rst_o === 1'b0 && fabric_rst_o === 1'b0, "master reset");
		$display("test chip reset finished");
	endtask
	initial
	begin
		void'($urandom(28));
		s = 8'($urandom);
		strap_i <= s;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check(master_rst_o === 1'b1 && ext_rst_pullup_en_o === 1'b1, "por hold");
		por_n_i <= 1'b1;
		chip_seq(s);
		// Digital reset: soft straps reload, immune bit kept, pins not sampled again
		wb(1'b1, switch_reset_pkg::ADR_HARDWARE_CONFIG_REG, 32'h100 | 32'($urandom % 256));
		strap_i <= ~s;
		load_wait <= 8'(40 + $urandom % 30);
		wb(1'b1, switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG, 32'h1 << switch_reset_pkg::RC_DIG);
		repeat (2) @(negedge clk_i);
		check(digital_rst_o === 1'b1 && ready_o === 1'b0, "digital reset");
		check(host_if_rst_o === 1'b1, "host interface reset");
		check(xcvr_rst_o === 2'b00 && emu_rst_o === 1'b0, "transceivers spared");
		poll(switch_reset_pkg::ADR_HARDWARE_CONFIG_REG, switch_reset_pkg::HW_READY, 1'b1);
		check(q[7:0] === s && soft_straps_o === s, "soft straps");
		check(q[switch_reset_pkg::HW_IMM] === 1'b1 && straps_o === s, "immune, straps");
		$display("test digital reset finished");
		// Port A by request bit, port B by its own self-reset bit
		for (int p = 0; p < 2; p++)
		begin
			if (p == 1) wb(1'b1, switch_reset_pkg::ADR_XCVR_B, 32'h0100);
			hi_cnt = 0;
			if (p == 0) wb(1'b1, switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG, 32'h2);
			else wb(1'b1, switch_reset_pkg::ADR_XCVR_B, 32'h8000);
			repeat (2) @(negedge clk_i);
			check(xcvr_rst_o === 2'(1 << p) && eeprom_load_o === 1'b0, "one port");
			if (p == 0) poll(switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG, 1, 1'b0);
			else poll(switch_reset_pkg::ADR_XCVR_B, switch_reset_pkg::BC_SOFT, 1'b0);
			check(near(hi_cnt, XC), "transceiver reset length");
			check(p == 0 || q[switch_reset_pkg::BC_IMM] === 1'b1, "immune kept");
		end
		// Emulated transceiver through both bits
		for (int m = 0; m < 2; m++)
		begin
			hi_cnt = 0;
			n = m ? switch_reset_pkg::BC_SOFT : switch_reset_pkg::RC_EMU;
			wb(1'b1, m ? switch_reset_pkg::ADR_EMU : switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG, 32'h1 << n);
			@(negedge clk_i);
			check(emu_rst_o === 1'b1 && xcvr_rst_o === 2'b00, "emulated only");
			poll(m ? switch_reset_pkg::ADR_EMU : switch_reset_pkg::ADR_SOFT_RESET_CONTROL_REG, n, 1'b0);
			check(near(hi_cnt, int'(switch_reset_pkg::EMU_CYC)), "emulated length");
		end
		$display("test module resets finished");
		// Fabric holds until cleared; time-sync clears itself
		wb(1'b1, switch_reset_pkg::ADR_FABRIC, 32'h1);
		wb(1'b0, switch_reset_pkg::ADR_FABRIC, 32'h0);
		check(fabric_rst_o === 1'b1 && q[0] === 1'b1, "fabric held");
		wb(1'b1, switch_reset_pkg::ADR_FABRIC, 32'h0);
		@(negedge clk_i);
		check(fabric_rst_o === 1'b0, "fabric cleared");
		wb(1'b1, switch_reset_pkg::ADR_TIMESYNC, 32'h1);
		@(negedge clk_i);
		check(timesync_rst_o === 1'b1, "timesync reset");
		poll(switch_reset_pkg::ADR_TIMESYNC, switch_reset_pkg::TS_RST, 1'b0);
		check(timesync_rst_o === 1'b0, "timesync done");
		// Leaving power-down resets port A but leaves its register alone
		wb(1'b1, switch_reset_pkg::ADR_XCVR_A, 32'h0900);
		wb(1'b1, switch_reset_pkg::ADR_XCVR_A, 32'h0100);
		repeat (2) @(negedge clk_i);
		check(xcvr_rst_o === 2'b01, "power-down exit reset");
		wb(1'b0, switch_reset_pkg::ADR_XCVR_A, 32'h0);
		check(q[15:0] === 16'h0100, "register untouched");
		$display("test single resets finished");
		// Pin reset latches fresh straps
		s = ~s;
		pin_req <= 1'b1;
		@(posedge clk_i);
		pin_req <= 1'b0;
		repeat (6) @(negedge clk_i);
		check(master_rst_o === 1'b1 && ready_o === 1'b0, "pin reset");
		tune_cnt = 0;
		oe_cnt = 0;
		chip_seq(s);
		print_verdict();
	end
endmodule // switch_reset_sequencer_tb
